// ===== logic/fwsr_ctrl.sv
/*
 * Host-side flash status poller: APB registers, single cycles, toggle-bit
 * completion polling with failure recovery, and guarded sector-erase adds.
 * Assumes flash pins are synchronous to pclk and the APB master is standard.
 */
// The register addresses and the APB slave port were left to the implementer.
//
// Contract
// - Host starts status check with two consecutive reads, comparing the toggle bit.
// - Same toggle value on two reads means done; next read returns array data.
// - Toggling with timeout flag high: recheck; stopped means success, else reset.
// - Returning to a check restarts the procedure from its first double read.
// - After any timeout failure the host writes the reset command.
// - Host may skip window checks only if adds come under 50 us apart.
// - Check window flag before and after each add; high after means maybe rejected.
`timescale 1ns/10ps
`default_nettype none
module fwsr_ctrl #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    output var  logic          irq,
    output wire logic [AW-1:0] flash_addr,
    output wire logic [DW-1:0] flash_dq_o,
    output wire logic          flash_dq_oe,
    input  wire logic [DW-1:0] flash_dq_i,
    output wire logic          flash_ce_n,
    output wire logic          flash_oe_n,
    output wire logic          flash_we_n,
    input  wire logic          ready_busy_output
);
    import fwsr_pkg::*;

    fwsr_cyc_if #(.AW(AW), .DW(DW)) cyc ();

    fwsr_cyc_eng #(.AW(AW), .DW(DW)) u_eng (
        .pclk        (pclk),
        .presetn     (presetn),
        .cyc         (cyc.eng),
        .flash_addr  (flash_addr),
        .flash_dq_o  (flash_dq_o),
        .flash_dq_oe (flash_dq_oe),
        .flash_dq_i  (flash_dq_i),
        .flash_ce_n  (flash_ce_n),
        .flash_oe_n  (flash_oe_n),
        .flash_we_n  (flash_we_n)
    );

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    fwsr_state_t        st_r;
    fwsr_op_t           op_r;
    logic [AW-1:0]      addr_r;
    logic [DW-1:0]      wdata_r;
    logic [DW-1:0]      rdata_r;
    logic               ok_r;
    logic               fail_r;
    logic               window_r;
    logic               reject_r;
    logic               refused_r;
    logic               tog_r;
    logic [15:0]        polls_r;
    logic [IRQ_N-1:0]   irq_st_r;
    logic [IRQ_N-1:0]   irq_en_r;
    logic               rdy_d_r;
    logic               req_r;
    logic               wr_r;
    logic [AW-1:0]      cyc_addr_r;
    logic [DW-1:0]      cyc_wdata_r;

    logic               wr_acc;
    logic               start;
    logic               busy;
    logic [IRQ_N-1:0]   irq_set;
    logic               ev_done;
    logic               ev_fail;
    logic               tog_now;
    logic               fail_now;
    logic               win_now;

    assign busy     = (st_r != S_IDLE);
    assign wr_acc   = psel && penable && pwrite && !pready;
    assign start    = wr_acc && (paddr == OFS_CTRL) && !busy;
    assign tog_now  = cyc.rdata[TOGGLE_STATUS_FIRST_POS];
    assign fail_now = cyc.rdata[TIMEOUT_FAIL_FLAG_POS];
    assign win_now  = cyc.rdata[ERASE_WINDOW_FLAG_POS];

    assign cyc.req   = req_r;
    assign cyc.wr    = wr_r;
    assign cyc.addr  = cyc_addr_r;
    assign cyc.wdata = cyc_wdata_r;

    // ------------------------------------------------------------
    // APB slave: one wait state, unmapped offsets answer with error
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && penable && !pready) begin
                case (paddr)
                    OFS_CTRL:    prdata <= {29'h0, op_r};
                    OFS_ADDR:    prdata <= 32'(addr_r);
                    OFS_WDATA:   prdata <= 32'(wdata_r);
                    OFS_STATUS:  prdata <= {25'h0, refused_r, reject_r, ready_busy_output,
                                            window_r, fail_r, ok_r, busy};
                    OFS_RDATA:   prdata <= 32'(rdata_r);
                    OFS_IRQ_ST:  prdata <= 32'(irq_st_r);
                    OFS_IRQ_EN:  prdata <= 32'(irq_en_r);
                    OFS_IRQ_CLR: prdata <= 32'h0000_0000;
                    OFS_POLLS:   prdata <= 32'(polls_r);
                    default:     pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Software setup registers; writes while busy are held off for addr and data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r   <= '0;
            wdata_r  <= '0;
            irq_en_r <= '0;
            op_r     <= OP_READ;
        end else if (wr_acc) begin
            case (paddr)
                OFS_ADDR:   if (!busy) addr_r <= pwdata[AW-1:0];
                OFS_WDATA:  if (!busy) wdata_r <= pwdata[DW-1:0];
                OFS_IRQ_EN: irq_en_r <= pwdata[IRQ_N-1:0];
                OFS_CTRL:   if (!busy) op_r <= fwsr_op_t'(pwdata[2:0]);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= S_IDLE;
            req_r       <= 1'b0;
            wr_r        <= 1'b0;
            cyc_addr_r  <= '0;
            cyc_wdata_r <= '0;
            tog_r       <= 1'b0;
            rdata_r     <= '0;
            ok_r        <= 1'b0;
            fail_r      <= 1'b0;
            window_r    <= 1'b0;
            reject_r    <= 1'b0;
            refused_r   <= 1'b0;
            polls_r     <= '0;
            ev_done     <= 1'b0;
            ev_fail     <= 1'b0;
        end else begin
            req_r   <= 1'b0;
            ev_done <= 1'b0;
            ev_fail <= 1'b0;
            if (cyc.done && !wr_r) begin
                rdata_r <= cyc.rdata;
            end
            case (st_r)
                S_IDLE: begin
                    if (start) begin
                        ok_r        <= 1'b0;
                        fail_r      <= 1'b0;
                        reject_r    <= 1'b0;
                        refused_r   <= 1'b0;
                        req_r       <= 1'b1;
                        cyc_addr_r  <= addr_r;
                        cyc_wdata_r <= wdata_r;
                        case (fwsr_op_t'(pwdata[2:0]))
                            OP_POLL: begin
                                polls_r <= '0;
                                wr_r    <= 1'b0;
                                st_r    <= S_RD1;
                            end
                            OP_ADD: begin
                                wr_r <= 1'b0;
                                st_r <= S_WPRE;
                            end
                            OP_WRITE: begin
                                wr_r <= 1'b1;
                                st_r <= S_SGL;
                            end
                            OP_RESET: begin
                                wr_r        <= 1'b1;
                                cyc_wdata_r <= DW'(CMD_RESET);
                                st_r        <= S_SGL;
                            end
                            default: begin
                                wr_r <= 1'b0;
                                st_r <= S_SGL;
                            end
                        endcase
                    end
                end
                S_RD1: begin
                    if (cyc.done) begin
                        tog_r <= tog_now;
                        req_r <= 1'b1;
                        st_r  <= S_RD2;
                    end
                end
                S_RD2: begin
                    if (cyc.done) begin
                        polls_r <= polls_r + 1'b1;
                        if (tog_now == tog_r) begin
                            ok_r    <= 1'b1;
                            ev_done <= 1'b1;
                            st_r    <= S_IDLE;
                        end else if (fail_now) begin
                            // Toggle may stop just as the timeout flag rises
                            tog_r <= tog_now;
                            req_r <= 1'b1;
                            st_r  <= S_RD3;
                        end else begin
                            // Each new look opens with a fresh double read
                            req_r <= 1'b1;
                            st_r  <= S_RD1;
                        end
                    end
                end
                S_RD3: begin
                    if (cyc.done) begin
                        if (tog_now == tog_r) begin
                            ok_r    <= 1'b1;
                            ev_done <= 1'b1;
                            st_r    <= S_IDLE;
                        end else begin
                            req_r       <= 1'b1;
                            wr_r        <= 1'b1;
                            cyc_wdata_r <= DW'(CMD_RESET);
                            st_r        <= S_RST;
                        end
                    end
                end
                S_RST: begin
                    if (cyc.done) begin
                        wr_r    <= 1'b0;
                        fail_r  <= 1'b1;
                        ev_fail <= 1'b1;
                        ev_done <= 1'b1;
                        st_r    <= S_IDLE;
                    end
                end
                S_WPRE: begin
                    if (cyc.done) begin
                        window_r <= win_now;
                        if (win_now) begin
                            // Erase already running: an add would be ignored
                            refused_r <= 1'b1;
                            ev_done   <= 1'b1;
                            st_r      <= S_IDLE;
                        end else begin
                            req_r <= 1'b1;
                            wr_r  <= 1'b1;
                            st_r  <= S_WWR;
                        end
                    end
                end
                S_WWR: begin
                    if (cyc.done) begin
                        req_r <= 1'b1;
                        wr_r  <= 1'b0;
                        st_r  <= S_WPOST;
                    end
                end
                S_WPOST: begin
                    if (cyc.done) begin
                        window_r <= win_now;
                        reject_r <= win_now;
                        ok_r     <= !win_now;
                        ev_done  <= 1'b1;
                        st_r     <= S_IDLE;
                    end
                end
                S_SGL: begin
                    if (cyc.done) begin
                        if (op_r == OP_WINDOW) begin
                            window_r <= win_now;
                        end
                        wr_r    <= 1'b0;
                        ok_r    <= 1'b1;
                        ev_done <= 1'b1;
                        st_r    <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupts: sticky status, set beats a same-cycle clear
    // ------------------------------------------------------------
    assign irq_set = {ready_busy_output && !rdy_d_r, ev_fail, ev_done};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_d_r  <= 1'b1;
            irq_st_r <= '0;
            irq      <= 1'b0;
        end else begin
            rdy_d_r <= ready_busy_output;
            if (wr_acc && (paddr == OFS_IRQ_CLR)) begin
                irq_st_r <= (irq_st_r & ~pwdata[IRQ_N-1:0]) | irq_set;
            end else begin
                irq_st_r <= irq_st_r | irq_set;
            end
            irq <= |(irq_st_r & irq_en_r);
        end
    end

endmodule : fwsr_ctrl
`default_nettype wire

// ===== logic/fwsr_cyc_eng.sv
/*
 * Timed asynchronous read and write cycles on the flash pins.
 * Assumes the flash data input is stable by the end of the access count.
 */
`timescale 1ns/10ps
`default_nettype none
module fwsr_cyc_eng #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    fwsr_cyc_if.eng            cyc,
    output var  logic [AW-1:0] flash_addr,
    output var  logic [DW-1:0] flash_dq_o,
    output var  logic          flash_dq_oe,
    input  wire logic [DW-1:0] flash_dq_i,
    output var  logic          flash_ce_n,
    output var  logic          flash_oe_n,
    output var  logic          flash_we_n
);
    import fwsr_pkg::*;

    fwsr_eng_t          st_r;
    logic [CNT_W-1:0]   cnt_r;

    // ------------------------------------------------------------
    // Cycle timing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= E_IDLE;
            cnt_r       <= '0;
            flash_addr  <= '0;
            flash_dq_o  <= '0;
            flash_dq_oe <= 1'b0;
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            cyc.done    <= 1'b0;
            cyc.rdata   <= '0;
        end else begin
            cyc.done <= 1'b0;
            case (st_r)
                E_IDLE: begin
                    if (cyc.req) begin
                        flash_addr  <= cyc.addr;
                        flash_dq_o  <= cyc.wdata;
                        flash_dq_oe <= cyc.wr;
                        flash_ce_n  <= 1'b0;
                        flash_oe_n  <= cyc.wr;
                        flash_we_n  <= !cyc.wr;
                        cnt_r       <= cyc.wr ? CNT_W'(CYC_WP - 1) : CNT_W'(CYC_ACC - 1);
                        st_r        <= E_ACT;
                    end
                end
                E_ACT: begin
                    if (cnt_r == '0) begin
                        if (!flash_oe_n) begin
                            cyc.rdata <= flash_dq_i;
                        end
                        // Data stays driven one more cycle for hold after the write strobe
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        cnt_r      <= CNT_W'(CYC_REC - 1);
                        st_r       <= E_REC;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                E_REC: begin
                    flash_dq_oe <= 1'b0;
                    if (cnt_r == '0) begin
                        cyc.done <= 1'b1;
                        st_r     <= E_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: st_r <= E_IDLE;
            endcase
        end
    end

endmodule : fwsr_cyc_eng
`default_nettype wire

// ===== pkg/fwsr_cyc_if.sv
/*
 * One flash bus cycle request and its answer, between sequencer and engine.
 * Assumes req is a one-cycle pulse and is not raised again before done.
 */
`timescale 1ns/10ps
`default_nettype none
interface fwsr_cyc_if #(parameter int AW = 20, parameter int DW = 16);
    logic          req;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          done;
    logic [DW-1:0] rdata;

    modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fwsr_cyc_if
`default_nettype wire

// ===== pkg/fwsr_pkg.sv
/*
 * Constants, register map and state types of the flash status poller.
 * Assumes a 100 MHz APB clock and a parallel flash on asynchronous pins.
 */
package fwsr_pkg;

    // ------------------------------------------------------------
    // Clock and pin timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 10;
    localparam int T_ACC_NS     = 70;   // Read access, least
    localparam int T_WP_NS      = 35;   // Write pulse, least
    localparam int T_REC_NS     = 20;   // Strobe high between cycles, least
    localparam int CYC_ACC      = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_WP       = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_REC      = (T_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W        = 4;

    // ------------------------------------------------------------
    // Status bit positions on the data bus
    // ------------------------------------------------------------
    localparam int DATA_POLLING_BIT_POS       = 7;
    localparam int TOGGLE_STATUS_FIRST_POS    = 6;
    localparam int TIMEOUT_FAIL_FLAG_POS      = 5;
    localparam int ERASE_WINDOW_FLAG_POS      = 3;
    localparam int TOGGLE_STATUS_SECOND_POS   = 2;

    localparam logic [15:0] CMD_RESET         = 16'h00F0;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ADDR    = 8'h04;
    localparam logic [7:0] OFS_WDATA   = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_RDATA   = 8'h10;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFS_POLLS   = 8'h20;

    // Status register bits
    localparam int ST_BUSY      = 0;
    localparam int ST_OK        = 1;
    localparam int ST_FAIL      = 2;
    localparam int ST_WINDOW    = 3;
    localparam int ST_RDY       = 4;
    localparam int ST_REJECT    = 5;
    localparam int ST_REFUSED   = 6;

    // Interrupt bits
    localparam int IRQ_N        = 3;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_FAIL     = 1;
    localparam int IRQ_READY    = 2;

    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_WRITE  = 3'h1,
        OP_POLL   = 3'h2,
        OP_RESET  = 3'h3,
        OP_WINDOW = 3'h4,
        OP_ADD    = 3'h5
    } fwsr_op_t;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_RD1   = 4'h1,
        S_RD2   = 4'h3,
        S_RD3   = 4'h2,
        S_RST   = 4'h6,
        S_SGL   = 4'h7,
        S_WPRE  = 4'h5,
        S_WWR   = 4'h4,
        S_WPOST = 4'hC
    } fwsr_state_t;

    typedef enum logic [1:0] {
        E_IDLE = 2'h0,
        E_ACT  = 2'h1,
        E_REC  = 2'h3
    } fwsr_eng_t;

endpackage : fwsr_pkg

// ===== verif/fwsr_ctrl_asserts.sv
/* Port checker for fwsr_ctrl. Assumes one pclk domain and async presetn. */
`timescale 1ns/10ps
`default_nettype none
module fwsr_ctrl_asserts #(parameter int AW = 20) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [AW-1:0] flash_addr,
    input wire logic          flash_dq_oe,
    input wire logic          flash_ce_n,
    input wire logic          flash_oe_n,
    input wire logic          flash_we_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    err_with_ready_a: assert property (pslverr |-> pready && $past(psel && penable))
        else $error("pslverr stray");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata stray");
    read_width_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*7] ##1 flash_oe_n)
        else $error("read strobe width");
    read_gap_a: assert property ($rose(flash_oe_n) |-> flash_oe_n [*2])
        else $error("read recovery");
    write_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
        else $error("write strobe width");
    write_drive_a: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
        else $error("write not driven");
    read_float_a: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
        else $error("read bus clash");
    addr_hold_a: assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr))
        else $error("address moved");
endmodule : fwsr_ctrl_asserts
bind fwsr_ctrl fwsr_ctrl_asserts #(.AW(AW)) fwsr_ctrl_asserts_inst (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .flash_addr, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n);
`default_nettype wire

// ===== verif/fwsr_flash_model.sv
/* Behavioural flash status model for the poller bench. Assumes fwsr_ctrl pin timing. */
`timescale 1ns/10ps
`default_nettype none
module fwsr_flash_model (
    input  wire logic        arm,
    input  wire logic [3:0]  n_tog,
    input  wire logic        fail_in,
    input  wire logic        win_in,
    input  wire logic        win_nxt,
    input  wire logic [15:0] flash_dq_o,
    input  wire logic        flash_dq_oe,
    output var  logic [15:0] flash_dq_i,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    output var  logic        ready_busy_output
);
    import fwsr_pkg::*;
    logic [3:0] cnt_r  = 4'h0;
    logic       tog_r  = 1'b0;
    logic       fail_r = 1'b0;
    logic       win_r  = 1'b0;
    logic [7:0] stat;
    assign stat = {cnt_r == 4'h0, tog_r, fail_r, 1'b0, win_r, tog_r, 2'b00};
    // Released bus shows the inverse so a stale copy never passes
    assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? {8'h00, stat} : {8'hFF, ~stat};
    assign ready_busy_output = cnt_r == 4'h0 && !fail_r;
    always @(posedge arm) begin
        cnt_r  = n_tog;
        fail_r = fail_in;
        win_r  = win_in;
    end
    always @(posedge flash_oe_n) begin
        if (cnt_r != 4'h0) tog_r = !tog_r;
        if (cnt_r != 4'h0) cnt_r = cnt_r - 4'h1;
    end
    always @(posedge flash_we_n) begin
        if (flash_dq_oe && flash_dq_o == CMD_RESET) fail_r = 1'b0;
        if (flash_dq_oe && flash_dq_o == CMD_RESET) cnt_r = 4'h0;
        else if (flash_dq_oe) win_r = win_nxt;
    end
endmodule : fwsr_flash_model
`default_nettype wire

// ===== verif/tb_top.sv
/* Self-checking bench for fwsr_ctrl. Assumes the flash model on its pins. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import fwsr_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        arm = 1'b0, fail_in = 1'b0, win_in = 1'b0, win_nxt = 1'b0, er;
    logic        pready, pslverr, irq, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, ready_busy_output;
    logic [3:0]  n_tog = 4'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_o, flash_dq_i;
    int          err_count, samples_checked;
    fwsr_ctrl fwsr_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n,
        .flash_oe_n, .flash_we_n, .ready_busy_output);
    fwsr_flash_model fwsr_flash_model_inst (.arm, .n_tog, .fail_in, .win_in, .win_nxt, .flash_dq_o,
        .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_oe_n, .flash_we_n, .ready_busy_output);
    initial begin
        forever #5 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Bounded wait: a missing pready must not hang the run
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) err_count++;
        if (i == 50) stop_test();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic launch(input logic [3:0] n, input logic f, w0, w1, input fwsr_op_t op);
        int k;
        n_tog   <= n;
        fail_in <= f;
        win_in  <= w0;
        win_nxt <= w1;
        @(posedge pclk) arm <= 1'b1;
        @(posedge pclk) arm <= 1'b0;
        apb(1'b1, OFS_CTRL, {29'h0, op});
        for (k = 0; k < 100; k++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd[ST_BUSY] === 1'b0) return;
        end
        err_count++;
        stop_test();
    endtask : launch
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, 8'h3C, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        chk("irq_st", 32'h0, rd);
        $display("test regs done");
    endtask : t_regs
    task automatic t_poll;
        launch(4'h0, 1'b0, 1'b0, 1'b0, OP_POLL);
        chk("quick", 32'h12, rd & 32'h17);
        chk("masked irq", 32'h0, {31'h0, irq});
        launch(4'h5, 1'b0, 1'b0, 1'b0, OP_POLL);
        chk("toggling", 32'h12, rd & 32'h17);
        apb(1'b0, OFS_POLLS, 32'h0);
        chk("polls", 32'h4, rd);
        launch(4'h1, 1'b1, 1'b0, 1'b0, OP_POLL);
        chk("late stop", 32'h02, rd & 32'h07);
        $display("test poll done");
    endtask : t_poll
    task automatic t_fail;
        apb(1'b1, OFS_IRQ_EN, 32'h2);
        launch(4'hF, 1'b1, 1'b0, 1'b0, OP_POLL);
        chk("fail", 32'h04, rd & 32'h07);
        chk("reset cmd", 32'h1, {31'h0, ready_busy_output});
        @(negedge pclk);
        chk("irq set", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_IRQ_CLR, 32'h7);
        repeat (3) @(posedge pclk);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("test fail done");
    endtask : t_fail
    task automatic t_add;
        launch(4'h0, 1'b0, 1'b0, 1'b1, OP_ADD);
        chk("reject", 32'h20, rd & 32'h22);
        launch(4'h0, 1'b0, 1'b1, 1'b1, OP_ADD);
        chk("refused", 32'h40, rd & 32'h40);
        launch(4'h0, 1'b0, 1'b0, 1'b0, OP_ADD);
        chk("accepted", 32'h02, rd & 32'h22);
        launch(4'h0, 1'b0, 1'b1, 1'b1, OP_WINDOW);
        chk("window", 32'h08, rd & 32'h08);
        launch(4'h0, 1'b0, 1'b0, 1'b0, OP_READ);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk("rdata", 32'h80, rd & 32'hFFBB);
        launch(4'h0, 1'b1, 1'b0, 1'b0, OP_RESET);
        chk("reset op", 32'h12, rd & 32'h16);
        $display("test add done");
    endtask : t_add
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_poll();
        t_fail();
        t_add();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
